/* hw/supply_serial_master.sv */
/*
  Write-only three-wire serial master. A command write with the register
  select low to one of eleven supply control registers sends one 16-bit
  frame (register number, then data, MSB first) to an external supply chip.
  Assumes the command port is driven by logic on mclk, one word per pulse.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Supply register write starts a frame automatically
// - Select low for whole frame, high after
// - Data changes on falling link clock edges
// - Shifting starts after select low, per fall
// - Frame is exactly sixteen bits, three lines
// - First byte register number, second byte data
// - Most significant bit first, bit fifteen leads
// - Numbers 38-42, 60-65 select supply registers
module supply_serial_master #(
  parameter int HALF_CYC = supply_link_pkg::LINK_HALF_CYC
) (
  input  wire logic                                 mclk,
  input  wire logic                                 rst,
  input  wire logic                                 cmd_write,
  input  wire logic                                 reg_or_ram_select,
  input  wire logic [supply_link_pkg::CMD_WIDTH-1:0] cmd_word,
  output logic                                      supply_link_select_n,
  output logic                                      supply_link_clock,
  output logic                                      supply_link_data,
  output logic                                      link_busy,
  output logic                                      supply_dc_select_hi,
  output logic                                      supply_dc_select_lo
);
  import supply_link_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_TAIL
  } link_state_t;

  link_state_t state_q;
  link_state_t state_d;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [4:0]  bits_q;
  logic [4:0]  bits_d;
  logic        sel_n_q;
  logic        sel_n_d;
  logic        sclk_q;
  logic        sclk_d;
  logic        sdo_q;
  logic        sdo_d;
  logic        busy_q;
  logic        busy_d;
  logic        dc_hi_q;
  logic        dc_hi_d;
  logic        dc_lo_q;
  logic        dc_lo_d;
  logic        tick;
  logic        restart;
  logic        supply_hit;
  logic [7:0]  reg_num;
  logic [7:0]  reg_data;

  // Register number selects one of the two supply ranges
  function automatic logic is_supply_reg(input logic [7:0] num);
    is_supply_reg = ((num >= SUPPLY_CTRL_1) && (num <= SUPPLY_CTRL_5)) ||
                    ((num >= SUPPLY_CTRL_6) && (num <= SUPPLY_CTRL_11));
  endfunction : is_supply_reg

  // Command decode; register select must be low for a register write
  assign reg_num    = cmd_word[CMD_NUM_MSB:CMD_NUM_LSB];
  assign reg_data   = cmd_word[CMD_DATA_MSB:CMD_DATA_LSB];
  assign supply_hit = cmd_write && !reg_or_ram_select && is_supply_reg(reg_num);

  // A frame start realigns the half-period divider
  assign restart = supply_hit && (state_q == ST_IDLE);

  link_tick_divider #(
    .HALF_CYC (HALF_CYC)
  ) u_divider (
    .mclk    (mclk),
    .rst     (rst),
    .restart (restart),
    .tick    (tick)
  );

  // Shadow of the converter select bits, kept even if a write lands mid-frame
  always_comb begin
    dc_hi_d = dc_hi_q;
    dc_lo_d = dc_lo_q;
    if (supply_hit && (reg_num == SUPPLY_CTRL_4)) begin
      dc_hi_d = reg_data[DC_HI_BIT];
      dc_lo_d = reg_data[DC_LO_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dc_hi_q <= DC_RESET;
      dc_lo_q <= DC_RESET;
    end else begin
      dc_hi_q <= dc_hi_d;
      dc_lo_q <= dc_lo_d;
    end
  end

  // Frame sequencer; a write during a frame is not queued, the host
  // is expected to wait for the frame to finish
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bits_d  = bits_q;
    sel_n_d = sel_n_q;
    sclk_d  = sclk_q;
    sdo_d   = sdo_q;
    case (state_q)
      ST_IDLE: begin
        sclk_d = CLOCK_IDLE;
        sdo_d  = DATA_IDLE;
        if (supply_hit) begin
          sel_n_d = 1'b0;
          shift_d = {reg_num, reg_data};
          bits_d  = BITS_RESET;
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          sclk_d  = 1'b0;
          sdo_d   = shift_q[15];
          shift_d = {shift_q[14:0], 1'b0};
          state_d = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tick) begin
          sclk_d = 1'b1;                             // Receiver samples here
          bits_d = bits_q + 5'h01;
          if (bits_q == FRAME_LAST_BIT) begin
            state_d = ST_TAIL;
          end else begin
            state_d = ST_HIGH;
          end
        end
      end
      ST_HIGH: begin
        if (tick) begin
          sclk_d  = 1'b0;
          sdo_d   = shift_q[15];
          shift_d = {shift_q[14:0], 1'b0};
          state_d = ST_LOW;
        end
      end
      ST_TAIL: begin
        if (tick) begin
          sel_n_d = SEL_N_IDLE;
          sdo_d   = DATA_IDLE;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        sel_n_d = SEL_N_IDLE;
        sclk_d  = CLOCK_IDLE;
        sdo_d   = DATA_IDLE;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // Reset drops any frame in flight and returns select, clock and data to idle levels at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      shift_q <= FRAME_RESET;
      bits_q  <= BITS_RESET;
      sel_n_q <= SEL_N_IDLE;
      sclk_q  <= CLOCK_IDLE;
      sdo_q   <= DATA_IDLE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bits_q  <= bits_d;
      sel_n_q <= sel_n_d;
      sclk_q  <= sclk_d;
      sdo_q   <= sdo_d;
      busy_q  <= busy_d;
    end
  end

  // All outputs straight from flip-flops
  assign supply_link_select_n = sel_n_q;
  assign supply_link_clock    = sclk_q;
  assign supply_link_data     = sdo_q;
  assign link_busy            = busy_q;
  assign supply_dc_select_hi  = dc_hi_q;
  assign supply_dc_select_lo  = dc_lo_q;

endmodule : supply_serial_master

`default_nettype wire

/* hw/supply_link_pkg.sv */
/*
  Constants for the write-only serial master that forwards supply settings
  to an external supply chip: register numbers, field positions, reset
  values and the link timing in nanoseconds and mclk cycles.
  Assumes a 250 MHz mclk; the link timing is derived from that period.
*/
package supply_link_pkg;

  // Supply control register numbers, carried in the upper command byte
  localparam logic [7:0] SUPPLY_CTRL_1  = 8'h26;
  localparam logic [7:0] SUPPLY_CTRL_2  = 8'h27;
  localparam logic [7:0] SUPPLY_CTRL_3  = 8'h28;
  localparam logic [7:0] SUPPLY_CTRL_4  = 8'h29;
  localparam logic [7:0] SUPPLY_CTRL_5  = 8'h2a;
  localparam logic [7:0] SUPPLY_CTRL_6  = 8'h3c;
  localparam logic [7:0] SUPPLY_CTRL_7  = 8'h3d;
  localparam logic [7:0] SUPPLY_CTRL_8  = 8'h3e;
  localparam logic [7:0] SUPPLY_CTRL_9  = 8'h3f;
  localparam logic [7:0] SUPPLY_CTRL_10 = 8'h40;
  localparam logic [7:0] SUPPLY_CTRL_11 = 8'h41;

  // Command word layout
  localparam int CMD_WIDTH    = 16;
  localparam int CMD_NUM_MSB  = 15;
  localparam int CMD_NUM_LSB  = 8;
  localparam int CMD_DATA_MSB = 7;
  localparam int CMD_DATA_LSB = 0;

  // Fields of supply_ctrl_4
  localparam int DC_HI_BIT = 4;
  localparam int DC_LO_BIT = 3;

  // Frame shape
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h0f;

  // Values after reset
  localparam logic [15:0] FRAME_RESET   = 16'h0000;
  localparam logic [4:0]  BITS_RESET    = 5'h00;
  localparam logic        SEL_N_IDLE    = 1'b1;
  localparam logic        CLOCK_IDLE    = 1'b1;
  localparam logic        DATA_IDLE     = 1'b0;
  localparam logic        DC_RESET      = 1'b0;

  // Timing: mclk period and least half period of the link clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINK_HALF_NS  = 80;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : supply_link_pkg

/* hw/link_tick_divider.sv */
/*
  Divider that turns mclk into a one-cycle enable pulse once every
  HALF_CYC cycles, marking each half period of the supply link clock.
  Assumes restart is a same-clock pulse that realigns the phase.
*/
`timescale 1ns/1ps
`default_nettype none

module link_tick_divider #(
  parameter int HALF_CYC = 20
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);

  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          tick_q;
  logic          tick_d;

  // Restart clears the phase so the first half period is always full
  always_comb begin
    count_d = count_q;
    tick_d  = 1'b0;
    if (restart) begin
      count_d = '0;
    end else if (count_q == LAST) begin
      count_d = '0;
      tick_d  = 1'b1;
    end else begin
      count_d = count_q + CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : link_tick_divider

`default_nettype wire

/* bench/supply_link_asserts.sv */
/*
  Port assertions for the supply link serial master.
  Assumes one mclk domain and is bound into every supply_serial_master.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_link_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        cmd_write,
  input wire logic        reg_or_ram_select,
  input wire logic [15:0] cmd_word,
  input wire logic        supply_link_select_n,
  input wire logic        supply_link_clock,
  input wire logic        supply_link_data,
  input wire logic        link_busy,
  input wire logic        supply_dc_select_hi,
  input wire logic        supply_dc_select_lo
);
  import supply_link_pkg::*;
  logic       clk_q, clk_d;
  logic [4:0] rise_q, rise_d;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Count link clock rises; cleared while deselected so each frame starts at zero
  always_comb begin
    clk_d  = supply_link_clock;
    rise_d = supply_link_select_n ? 5'h00 : rise_q + {4'h0, supply_link_clock & ~clk_q};
  end
  always_ff @(posedge mclk) begin
    clk_q  <= clk_d;
    rise_q <= rise_d;
  end
  sequence go_s;
    cmd_write && !reg_or_ram_select && !link_busy &&
      (cmd_word[15:8] inside {[8'h26:8'h2a], [8'h3c:8'h41]});
  endsequence
  sequence started_s;
    !supply_link_select_n && link_busy;
  endsequence
  chk_auto_start: assert property (go_s |=> started_s)
    else $error("frame did not start");
  chk_busy_select: assert property (link_busy == !supply_link_select_n)
    else $error("busy and select disagree");
  chk_frame_ends: assert property ($fell(supply_link_select_n) |-> ##[1:1000] $rose(supply_link_select_n))
    else $error("frame never ended");
  chk_data_on_fall: assert property ($changed(supply_link_data) && !supply_link_select_n |-> $fell(supply_link_clock))
    else $error("data moved off a falling edge");
  chk_shift_late: assert property ($fell(supply_link_select_n) |-> supply_link_clock[*8])
    else $error("clock fell too soon after select");
  chk_sixteen_rises: assert property ($rose(supply_link_select_n) && !$past(rst) |-> rise_q == 5'h10)
    else $error("frame bit count wrong");
  chk_idle_levels: assert property (supply_link_select_n |-> supply_link_clock && !supply_link_data)
    else $error("idle levels wrong");
  chk_ram_refused: assert property (cmd_write && reg_or_ram_select && !link_busy |=> supply_link_select_n)
    else $error("ram write started a frame");
  chk_dc_bits: assert property (cmd_write && !reg_or_ram_select && cmd_word[15:8] == 8'h29
    |=> {supply_dc_select_hi, supply_dc_select_lo} == $past(cmd_word[4:3]))
    else $error("dc select bits wrong");
  chk_reset_idle: assert property (disable iff (1'b0) rst |=> supply_link_select_n && supply_link_clock && !link_busy)
    else $error("reset left link active");
endmodule : supply_link_asserts
bind supply_serial_master supply_link_asserts u_chk (.mclk(mclk), .rst(rst), .cmd_write(cmd_write),
  .reg_or_ram_select(reg_or_ram_select), .cmd_word(cmd_word),
  .supply_link_select_n(supply_link_select_n), .supply_link_clock(supply_link_clock),
  .supply_link_data(supply_link_data), .link_busy(link_busy),
  .supply_dc_select_hi(supply_dc_select_hi), .supply_dc_select_lo(supply_dc_select_lo));
`default_nettype wire

/* bench/supply_chip_model.sv */
/*
  Behavioural external supply chip: shifts in frames from the link.
  Assumes it only listens; it drives nothing back to the master.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_chip_model (
  input  wire logic       sel_n,
  input  wire logic       sclk,
  input  wire logic       sdata,
  output logic      [7:0] index_q,
  output logic      [7:0] value_q,
  output logic      [7:0] frames_q
);
  logic [15:0] shift_q;
  logic [4:0]  bits_q;
  initial begin
    {index_q, value_q, frames_q, shift_q, bits_q} = '0;
  end
  // Sample on the rise, half a period after the data moved
  always @(posedge sclk) begin
    if (sel_n === 1'b0) begin
      shift_q <= {shift_q[14:0], sdata};
      bits_q  <= bits_q + 5'h01;
    end
  end
  // Count restarts when select falls; the clock idles high then, so no race
  always @(negedge sel_n) begin
    bits_q <= 5'h00;
  end
  // Byte one is the index, byte two its data; a cut frame is dropped
  always @(posedge sel_n) begin
    if (bits_q == 5'h10) begin
      {index_q, value_q} <= shift_q;
      frames_q           <= frames_q + 8'h01;
    end
  end
endmodule : supply_chip_model
`default_nettype wire

/* bench/tb_top.sv */
/*
  Self-checking bench for the supply link master and its far-side chip.
  Assumes the command port is pulsed for one mclk per write.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import supply_link_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, cmd_write = 1'b0, reg_or_ram_select = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  wire logic   sel_n, sclk, sdata, busy, dc_hi, dc_lo;
  wire logic [7:0] idx, val, frames;
  int          mismatches = 0;
  int          checked = 0;
  // Rows: command word, then expected dc select bits afterwards
  localparam logic [17:0] ROWS [12] = '{{16'h2601, 2'b00}, {16'h27fe, 2'b00},
    {16'h2855, 2'b00}, {16'h2910, 2'b10}, {16'h2aaa, 2'b10}, {16'h3c80, 2'b10},
    {16'h3d01, 2'b10}, {16'h3e7f, 2'b10}, {16'h3fc3, 2'b10}, {16'h4000, 2'b10},
    {16'h41ff, 2'b10}, {16'h2908, 2'b01}};
  // Refused writes: ram flag, then word
  localparam logic [16:0] BAD [5] = '{{1'b0, 16'h2512}, {1'b0, 16'h2b12},
    {1'b0, 16'h3b12}, {1'b0, 16'h4212}, {1'b1, 16'h2612}};
  initial begin
    forever #2 mclk = ~mclk;
  end
  supply_serial_master #(.HALF_CYC(20)) u_supply_serial_master (.mclk(mclk), .rst(rst),
    .cmd_write(cmd_write), .reg_or_ram_select(reg_or_ram_select), .cmd_word(cmd_word),
    .supply_link_select_n(sel_n), .supply_link_clock(sclk), .supply_link_data(sdata),
    .link_busy(busy), .supply_dc_select_hi(dc_hi), .supply_dc_select_lo(dc_lo));
  supply_chip_model u_supply_chip_model (.sel_n(sel_n), .sclk(sclk), .sdata(sdata),
    .index_q(idx), .value_q(val), .frames_q(frames));
  task stop_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task send(input logic [15:0] w, input logic ram);
    @(negedge mclk);
    {cmd_write, reg_or_ram_select, cmd_word} = {1'b1, ram, w};
    @(negedge mclk);
    cmd_write = 1'b0;
  endtask : send
  // Frames last about 700 mclk; 2000 is a generous hang limit
  // The next write waits for the frame to finish, standing in for the host gap
  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_idle
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      send(ROWS[i][17:2], 1'b0);
      wait_idle();
      `CHK({idx, val}, ROWS[i][17:2])
      `CHK(frames, 8'(i + 1))
      `CHK({dc_hi, dc_lo}, ROWS[i][1:0])
    end
    // A second write inside a frame must not disturb it
    send(16'h2633, 1'b0);
    repeat (100) @(negedge mclk);
    send(16'h2744, 1'b0);
    wait_idle();
    `CHK({idx, val}, 16'h2633)
    `CHK(frames, 8'd13)
    for (int i = 0; i < 5; i++) begin
      send(BAD[i][15:0], BAD[i][16]);
      `CHK(busy, 1'b0)
    end
    // Reset in mid-frame drops the frame and idles the link
    send(16'h3c5a, 1'b0);
    repeat (300) @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    `CHK({sel_n, sclk, sdata, busy, dc_hi, dc_lo}, 6'b110000)
    rst = 1'b0;
    repeat (700) @(negedge mclk);
    `CHK(frames, 8'd13)
    send(16'h3da5, 1'b0);
    wait_idle();
    `CHK({idx, val, frames}, 24'h3da50e)
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
